/* File: src/rbw_consts.svh */
// Offsets, field positions and reset values of the remap window base registers
`ifndef RBW_CONSTS_SVH
`define RBW_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets in the chipset register space
// ----------------------------------------------------------------
`define RBW_OFS_CHAN0     12'h020
`define RBW_OFS_CHAN1     12'h028
`define RBW_OFS_QW_MSB    11
`define RBW_OFS_QW_LSB    3

// ----------------------------------------------------------------
// Field layout of one window register
// ----------------------------------------------------------------
`define RBW_BASE_MSB      63
`define RBW_BASE_LSB      12
`define RBW_RSVD_MSB      11
`define RBW_RSVD_LSB      1
`define RBW_EN_BIT        0
`define RBW_RSVD_VAL      11'h000
`define RBW_OFFSET_MSB    11
`define RBW_OFFSET_LSB    0

// Base bits that correspond to address bits 63:32
`define RBW_HI_MSB        51
`define RBW_HI_LSB        20
`define RBW_HI_ZERO       32'h0000_0000

// Memory address bits that lie above the 4 GB range
`define RBW_ADDR_HI_MSB   63
`define RBW_ADDR_HI_LSB   32

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RBW_BASE_RST      52'h0_0000_0000_0000
`define RBW_EN_RST        1'h0
`define RBW_WORD_ZERO     64'h0000_0000_0000_0000
`define RBW_OFFSET_ZERO   12'h000

// ----------------------------------------------------------------
// Structure
// ----------------------------------------------------------------
`define RBW_NUM_BYTES     8
`define RBW_NUM_WIN       2
`define RBW_CHAN0         0
`define RBW_CHAN1         1

`endif

/* File: src/rbw_pkg.sv */
// Types shared by the remap window base register bank
package rbw_pkg;

    typedef logic [51:0] rbw_base_type;
    typedef logic [63:0] rbw_word_type;
    typedef logic [7:0]  rbw_be_type;
    typedef logic [11:0] rbw_offset_type;

    // One-hot selection of the remap register set that a claim reaches
    typedef enum logic [1:0] {
        RBW_SEL_CHAN0 = 2'h1,
        RBW_SEL_CHAN1 = 2'h2
    } rbw_sel_type;

endpackage

/* File: src/rbw_win_if.sv */
// Carrier between the bank, one window register and its decoder
`timescale 1ns/100ps
interface rbw_win_if;
    import rbw_pkg::*;

    logic         wr;
    rbw_be_type   be;
    rbw_word_type wdata;
    logic         wr_allow;
    rbw_base_type base;
    logic         en;
    logic         mem_valid;
    rbw_word_type mem_addr;
    logic         hit;

    modport ctl (output wr, output be, output wdata, output wr_allow,
                 output mem_valid, output mem_addr,
                 input base, input en, input hit);
    modport regs (input wr, input be, input wdata, input wr_allow,
                  output base, output en);
    modport dec (input base, input en, input mem_valid, input mem_addr,
                 output hit);
endinterface

/* File: src/rbw_window_reg.sv */
// One 64-bit window base register with byte enables and write lock
`timescale 1ns/100ps
`include "rbw_consts.svh"
module rbw_window_reg
    import rbw_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    rbw_win_if.regs   w
);

    rbw_word_type cur_word;
    rbw_word_type nxt_word;
    rbw_base_type base_ff;
    logic         en_ff;

    assign cur_word = {base_ff, `RBW_RSVD_VAL, en_ff};

    // ----------------------------------------------------------------
    // Byte merge
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `RBW_NUM_BYTES; gi++) begin : g_byte
            assign nxt_word[gi*8 +: 8] = w.be[gi] ? w.wdata[gi*8 +: 8] : cur_word[gi*8 +: 8];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Reserved bits 11:1 are never stored, so writes to them vanish
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            base_ff <= `RBW_BASE_RST;
            en_ff   <= `RBW_EN_RST;
        end else if (w.wr && w.wr_allow) begin
            base_ff <= nxt_word[`RBW_BASE_MSB:`RBW_BASE_LSB];
            en_ff   <= nxt_word[`RBW_EN_BIT];
        end
    end

    assign w.base = base_ff;
    assign w.en   = en_ff;

endmodule

/* File: src/rbw_window_decode.sv */
// Address match of one 4-KB remap window
`timescale 1ns/100ps
`include "rbw_consts.svh"
module rbw_window_decode
    import rbw_pkg::*;
(
    rbw_win_if.dec w
);

    logic base_match;
    logic below_4g;

    // Whole aligned block only: low 12 address bits never take part
    assign base_match = (w.mem_addr[`RBW_BASE_MSB:`RBW_BASE_LSB] == w.base);
    // A base above 4 GB is never claimed
    assign below_4g   = (w.base[`RBW_HI_MSB:`RBW_HI_LSB] == `RBW_HI_ZERO);
    assign w.hit      = w.mem_valid && w.en && base_match && below_4g;

endmodule

/* File: src/rbw_bank.sv */
// Remap window base register bank for two virtual-channel remap register sets
//
// Functional notes
// - Bits 63:12 hold a writable base; address bits below 12 are zero.
// - The base places one aligned 4-KB block inside the 4-GB range.
// - No memory behind the window; accesses reach only the remap registers.
// - Enable bit 0 clear means no access inside the window is claimed.
// - Enable bit set means window hits are claimed and decoded.
// - With remap capability disabled, base and enable ignore writes.
// - A locked parent register-space base also locks both window registers.
// - First window maps the channel 0 set for graphics port and link.
// - Second window maps the channel 1 set of the link only.
// - Second window register sits at offset 0x28 through 0x2F.
// - Bits 11:1 are reserved, read-only and return zero.
`timescale 1ns/100ps
`include "rbw_consts.svh"
module rbw_bank
    import rbw_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           remap_cap_en,
    input  wire logic           regspace_locked,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    input  wire rbw_offset_type reg_addr,
    input  wire rbw_be_type     reg_be,
    input  wire rbw_word_type   reg_wdata,
    output logic                reg_ack,
    output rbw_word_type        reg_rdata,
    input  wire logic           mem_valid,
    input  wire rbw_word_type   mem_addr,
    output logic                mem_claim,
    output rbw_sel_type         mem_sel,
    output rbw_offset_type      mem_offset,
    output logic                chan0_remap_window_en,
    output logic                chan1_remap_window_en
);

    // ----------------------------------------------------------------
    // Window instances
    // ----------------------------------------------------------------
    rbw_win_if win_if [`RBW_NUM_WIN] ();

    logic                    wr_allow;
    logic [`RBW_NUM_WIN-1:0] reg_sel;
    logic [`RBW_NUM_WIN-1:0] win_hit;
    rbw_base_type            win_base [`RBW_NUM_WIN];
    logic [`RBW_NUM_WIN-1:0] win_en;
    rbw_offset_type          win_ofs  [`RBW_NUM_WIN];

    assign win_ofs[`RBW_CHAN0] = `RBW_OFS_CHAN0;
    assign win_ofs[`RBW_CHAN1] = `RBW_OFS_CHAN1;

    // Both lock sources only gate writes; reads always return the image
    assign wr_allow = remap_cap_en && !regspace_locked;

    genvar gw;
    generate
        for (gw = 0; gw < `RBW_NUM_WIN; gw++) begin : g_win
            assign reg_sel[gw] = (reg_addr[`RBW_OFS_QW_MSB:`RBW_OFS_QW_LSB]
                                  == win_ofs[gw][`RBW_OFS_QW_MSB:`RBW_OFS_QW_LSB]);
            assign win_if[gw].wr        = reg_wr && reg_sel[gw];
            assign win_if[gw].be        = reg_be;
            assign win_if[gw].wdata     = reg_wdata;
            assign win_if[gw].wr_allow  = wr_allow;
            assign win_if[gw].mem_valid = mem_valid;
            assign win_if[gw].mem_addr  = mem_addr;
            assign win_base[gw]         = win_if[gw].base;
            assign win_en[gw]           = win_if[gw].en;
            assign win_hit[gw]          = win_if[gw].hit;

            rbw_window_reg u_reg (
                .clk_sys (clk_sys),
                .rst     (rst),
                .w       (win_if[gw])
            );

            rbw_window_decode u_dec (
                .w (win_if[gw])
            );
        end
    endgenerate

    assign chan0_remap_window_en = win_en[`RBW_CHAN0];
    assign chan1_remap_window_en = win_en[`RBW_CHAN1];

    // ----------------------------------------------------------------
    // Register read and acknowledge
    // ----------------------------------------------------------------
    logic         reg_ack_ff;
    rbw_word_type reg_rdata_ff;
    rbw_word_type nxt_rdata;

    always_comb begin
        nxt_rdata = `RBW_WORD_ZERO;
        if (reg_sel[`RBW_CHAN0]) begin
            nxt_rdata = {win_base[`RBW_CHAN0], `RBW_RSVD_VAL, win_en[`RBW_CHAN0]};
        end else if (reg_sel[`RBW_CHAN1]) begin
            nxt_rdata = {win_base[`RBW_CHAN1], `RBW_RSVD_VAL, win_en[`RBW_CHAN1]};
        end
    end

    // Unmapped offsets get no acknowledge; the parent space answers them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_ack_ff <= 1'h0;
        end else begin
            reg_ack_ff <= (reg_wr || reg_rd) && (|reg_sel);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_ff <= `RBW_WORD_ZERO;
        end else if (reg_rd && (|reg_sel)) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    assign reg_ack   = reg_ack_ff;
    assign reg_rdata = reg_rdata_ff;

    // ----------------------------------------------------------------
    // Memory claim
    // ----------------------------------------------------------------
    logic           mem_claim_ff;
    rbw_sel_type    mem_sel_ff;
    rbw_offset_type mem_offset_ff;

    // Overlapping windows resolve to channel 0 so a claim is never doubled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_claim_ff <= 1'h0;
            mem_sel_ff   <= RBW_SEL_CHAN0;
        end else begin
            mem_claim_ff <= |win_hit;
            if (win_hit[`RBW_CHAN0]) begin
                mem_sel_ff <= RBW_SEL_CHAN0;
            end else if (win_hit[`RBW_CHAN1]) begin
                mem_sel_ff <= RBW_SEL_CHAN1;
            end
        end
    end

    // Only the in-window offset goes on; nothing else sits behind the window
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_offset_ff <= `RBW_OFFSET_ZERO;
        end else if (|win_hit) begin
            mem_offset_ff <= mem_addr[`RBW_OFFSET_MSB:`RBW_OFFSET_LSB];
        end
    end

    assign mem_claim  = mem_claim_ff;
    assign mem_sel    = mem_sel_ff;
    assign mem_offset = mem_offset_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic full_wr1;
    logic full_wr0;
    assign full_wr1 = reg_wr && reg_sel[`RBW_CHAN1] && (&reg_be) && wr_allow;
    assign full_wr0 = reg_wr && reg_sel[`RBW_CHAN0] && (&reg_be) && wr_allow;

    a_chan1_base_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        full_wr1 |=> (win_base[`RBW_CHAN1] == $past(reg_wdata[`RBW_BASE_MSB:`RBW_BASE_LSB]))
                     && (win_en[`RBW_CHAN1] == $past(reg_wdata[`RBW_EN_BIT]))
    ) else $error("channel 1 register did not take a full write at 0x28");

    a_chan0_base_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        full_wr0 |=> (win_base[`RBW_CHAN0] == $past(reg_wdata[`RBW_BASE_MSB:`RBW_BASE_LSB]))
                     ##1 $stable(win_base[`RBW_CHAN0]) || $past(reg_wr)
    ) else $error("channel 0 base field did not take the written value");

    a_cap_off_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && !remap_cap_en) |=> $stable(win_base[`RBW_CHAN0]) && $stable(win_en)
                                      && $stable(win_base[`RBW_CHAN1])
    ) else $error("window register changed while remap capability was off");

    a_lock_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        regspace_locked [*2] |-> $stable(win_en) && $stable(win_base[`RBW_CHAN0])
                                 && $stable(win_base[`RBW_CHAN1])
    ) else $error("window register changed while parent space was locked");

    a_no_claim_off: assert property (
        @(posedge clk_sys) disable iff (rst)
        (win_en == 2'h0) |=> !mem_claim
    ) else $error("memory claimed with both windows disabled");

    a_claim_on_hit: assert property (
        @(posedge clk_sys) disable iff (rst)
        (mem_valid && win_en[`RBW_CHAN1]
         && (mem_addr[`RBW_BASE_MSB:`RBW_BASE_LSB] == win_base[`RBW_CHAN1])
         && (win_base[`RBW_CHAN1][`RBW_HI_MSB:`RBW_HI_LSB] == `RBW_HI_ZERO))
        |=> mem_claim && (mem_offset == $past(mem_addr[`RBW_OFFSET_MSB:`RBW_OFFSET_LSB]))
    ) else $error("enabled window hit was not claimed with its offset");

    a_chan0_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        win_hit[`RBW_CHAN0] |=> mem_claim && (mem_sel == RBW_SEL_CHAN0)
    ) else $error("channel 0 hit did not select the channel 0 set");

    a_chan1_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        (win_hit[`RBW_CHAN1] && !win_hit[`RBW_CHAN0]) |=> (mem_sel == RBW_SEL_CHAN1)
    ) else $error("channel 1 only hit did not select the channel 1 set");

    a_whole_window: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_claim |-> $past(mem_valid)
                      && (($past(mem_addr[`RBW_BASE_MSB:`RBW_BASE_LSB])
                           == $past(win_base[`RBW_CHAN0])) && $past(win_en[`RBW_CHAN0])
                          || ($past(mem_addr[`RBW_BASE_MSB:`RBW_BASE_LSB])
                           == $past(win_base[`RBW_CHAN1])) && $past(win_en[`RBW_CHAN1]))
    ) else $error("claim outside every enabled aligned window");

    // An address above 4 GB can only match a base above 4 GB, so it is never claimed
    a_below_4g: assert property (
        @(posedge clk_sys) disable iff (rst)
        (mem_valid
         && ((mem_addr[`RBW_ADDR_HI_MSB:`RBW_ADDR_HI_LSB] != `RBW_HI_ZERO)
             || ((win_base[`RBW_CHAN0][`RBW_HI_MSB:`RBW_HI_LSB] != `RBW_HI_ZERO)
                 && (win_base[`RBW_CHAN1][`RBW_HI_MSB:`RBW_HI_LSB] != `RBW_HI_ZERO))))
        |=> !mem_claim
    ) else $error("window above 4 GB was claimed");

    a_rsvd_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        (reg_rd && (|reg_sel)) |=> reg_ack
                                   && (reg_rdata[`RBW_RSVD_MSB:`RBW_RSVD_LSB] == `RBW_RSVD_VAL)
    ) else $error("reserved bits did not read as zero");

    a_reset_clear: assert property (
        @(posedge clk_sys)
        rst |=> (win_en == 2'h0) && (win_base[`RBW_CHAN0] == `RBW_BASE_RST)
                && (win_base[`RBW_CHAN1] == `RBW_BASE_RST) && !mem_claim
    ) else $error("reset did not clear the window registers");

    a_claim_offset: assert property (
        @(posedge clk_sys) disable iff (rst)
        mem_claim |-> (mem_offset == $past(mem_addr[`RBW_OFFSET_MSB:`RBW_OFFSET_LSB]))
    ) else $error("claimed offset does not match the access");

    a_claim_needs_valid: assert property (
        @(posedge clk_sys) disable iff (rst)
        !mem_valid |=> !mem_claim
    ) else $error("claim raised without a memory access");

    a_sel_one_hot: assert property (
        @(posedge clk_sys) disable iff (rst)
        (mem_sel == RBW_SEL_CHAN0) || (mem_sel == RBW_SEL_CHAN1)
    ) else $error("remap set selection is not one-hot");

    a_write_ack: assert property (
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && (|reg_sel)) |=> reg_ack
    ) else $error("mapped write was not acknowledged");

    a_unmapped_no_ack: assert property (
        @(posedge clk_sys) disable iff (rst)
        ((reg_wr || reg_rd) && !(|reg_sel)) |=> !reg_ack
    ) else $error("unmapped offset was acknowledged");

    a_idle_no_ack: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(reg_wr || reg_rd) |=> !reg_ack
    ) else $error("acknowledge without a register request");

    a_rdata_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(reg_rd && (|reg_sel)) |=> $stable(reg_rdata)
    ) else $error("read data changed without a mapped read");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------

    c_chan0_claim: cover property (
        @(posedge clk_sys) disable iff (rst)
        mem_claim && (mem_sel == RBW_SEL_CHAN0)
    );

    c_chan1_claim: cover property (
        @(posedge clk_sys) disable iff (rst)
        mem_claim && (mem_sel == RBW_SEL_CHAN1)
    );

    c_locked_write: cover property (
        @(posedge clk_sys) disable iff (rst)
        reg_wr && (|reg_sel) && regspace_locked
    );

    c_read_back: cover property (
        @(posedge clk_sys) disable iff (rst)
        full_wr0 ##1 (reg_rd && reg_sel[`RBW_CHAN0]) ##1 reg_ack
    );

    // Both windows hit at once: exercises the channel 0 priority
    c_overlap_hit: cover property (
        @(posedge clk_sys) disable iff (rst)
        &win_hit
    );

endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench for the remap window base register bank
`timescale 1ns/100ps
module tb_top;
    import rbw_pkg::*;

    // ----------------------------------------------------------------
    // Clock, reset and stimulus
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]   k;
        rbw_word_type a;
        rbw_be_type   b;
        rbw_word_type d;
        logic         f;
        rbw_word_type e;
    } rbw_row_type;

    localparam int NROWS     = 25;
    localparam int CYCLE_MAX = 1000;

    logic           clk_sys;
    logic           rst;
    logic           remap_cap_en;
    logic           regspace_locked;
    logic           reg_wr;
    logic           reg_rd;
    rbw_offset_type reg_addr;
    rbw_be_type     reg_be;
    rbw_word_type   reg_wdata;
    logic           reg_ack;
    rbw_word_type   reg_rdata;
    logic           mem_valid;
    rbw_word_type   mem_addr;
    logic           mem_claim;
    rbw_sel_type    mem_sel;
    rbw_offset_type mem_offset;
    logic           chan0_remap_window_en;
    logic           chan1_remap_window_en;
    int             failures;
    int             checks;
    int             cycle_cnt;

    // Kind 0 write, 1 read, 2 memory probe; e packs {sel, offset} for probes
    rbw_row_type rows [NROWS] = '{
        '{2'h0, 64'h20, 8'hFF, 64'h0000_0000_1234_5FFF, 1'h1, 64'h0},
        '{2'h1, 64'h20, 8'h00, 64'h0, 1'h1, 64'h0000_0000_1234_5001},
        '{2'h0, 64'h28, 8'hFF, 64'h0000_0000_ABCD_E7FF, 1'h1, 64'h0},
        '{2'h1, 64'h28, 8'h00, 64'h0, 1'h1, 64'h0000_0000_ABCD_E001},
        '{2'h1, 64'h2F, 8'h00, 64'h0, 1'h1, 64'h0000_0000_ABCD_E001},
        '{2'h1, 64'h30, 8'h00, 64'h0, 1'h0, 64'h0000_0000_ABCD_E001},
        '{2'h1, 64'h18, 8'h00, 64'h0, 1'h0, 64'h0000_0000_ABCD_E001},
        '{2'h2, 64'h0000_0000_1234_5ABC, 8'h00, 64'h0, 1'h1, 64'h1ABC},
        '{2'h2, 64'h0000_0000_ABCD_E004, 8'h00, 64'h0, 1'h1, 64'h2004},
        '{2'h2, 64'h0000_0000_1234_6000, 8'h00, 64'h0, 1'h0, 64'h0},
        '{2'h2, 64'h0000_0000_1234_4FFF, 8'h00, 64'h0, 1'h0, 64'h0},
        '{2'h2, 64'h0000_0001_1234_5000, 8'h00, 64'h0, 1'h0, 64'h0},
        '{2'h0, 64'h28, 8'h02, 64'h0000_0000_0000_F000, 1'h1, 64'h0},
        '{2'h1, 64'h28, 8'h00, 64'h0, 1'h1, 64'h0000_0000_ABCD_F001},
        '{2'h2, 64'h0000_0000_ABCD_F123, 8'h00, 64'h0, 1'h1, 64'h2123},
        '{2'h0, 64'h28, 8'hF0, 64'hFFFF_FFFF_0000_0000, 1'h1, 64'h0},
        '{2'h1, 64'h28, 8'h00, 64'h0, 1'h1, 64'hFFFF_FFFF_ABCD_F001},
        '{2'h2, 64'hFFFF_FFFF_ABCD_F123, 8'h00, 64'h0, 1'h0, 64'h0},
        '{2'h0, 64'h28, 8'hFF, 64'h0000_0000_ABCD_F000, 1'h1, 64'h0},
        '{2'h2, 64'h0000_0000_ABCD_F123, 8'h00, 64'h0, 1'h0, 64'h0},
        '{2'h0, 64'h28, 8'hFF, 64'h0000_0000_1234_5001, 1'h1, 64'h0},
        '{2'h2, 64'h0000_0000_1234_5010, 8'h00, 64'h0, 1'h1, 64'h1010},
        '{2'h0, 64'h20, 8'hFF, 64'h0000_0001_1234_5001, 1'h1, 64'h0},
        '{2'h1, 64'h20, 8'h00, 64'h0, 1'h1, 64'h0000_0001_1234_5001},
        '{2'h2, 64'h0000_0000_1234_5010, 8'h00, 64'h0, 1'h1, 64'h2010}
    };

    rbw_bank DUT (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .remap_cap_en          (remap_cap_en),
        .regspace_locked       (regspace_locked),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_addr              (reg_addr),
        .reg_be                (reg_be),
        .reg_wdata             (reg_wdata),
        .reg_ack               (reg_ack),
        .reg_rdata             (reg_rdata),
        .mem_valid             (mem_valid),
        .mem_addr              (mem_addr),
        .mem_claim             (mem_claim),
        .mem_sel               (mem_sel),
        .mem_offset            (mem_offset),
        .chan0_remap_window_en (chan0_remap_window_en),
        .chan1_remap_window_en (chan1_remap_window_en)
    );

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input rbw_word_type seen, input rbw_word_type exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Tasks start and end 1 ns after a rising edge; an idle cycle separates calls
    task automatic reg_write(input rbw_offset_type a, input rbw_be_type b,
                             input rbw_word_type d, input logic ack_exp);
        reg_wr    = 1'h1;
        reg_addr  = a;
        reg_be    = b;
        reg_wdata = d;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'h0;
        check({63'h0, reg_ack}, {63'h0, ack_exp});
        @(posedge clk_sys);
        #1;
    endtask

    task automatic reg_read(input rbw_offset_type a, input logic ack_exp,
                            input rbw_word_type d_exp);
        reg_rd   = 1'h1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'h0;
        check({63'h0, reg_ack}, {63'h0, ack_exp});
        check(reg_rdata, d_exp);
        @(posedge clk_sys);
        #1;
    endtask

    task automatic mem_probe(input rbw_word_type a, input logic claim_exp,
                             input rbw_word_type so_exp);
        mem_valid = 1'h1;
        mem_addr  = a;
        @(posedge clk_sys);
        #1;
        mem_valid = 1'h0;
        check({63'h0, mem_claim}, {63'h0, claim_exp});
        if (claim_exp) begin
            check({50'h0, mem_sel, mem_offset}, so_exp);
        end
        @(posedge clk_sys);
        #1;
    endtask

    always @(posedge clk_sys) begin
        cycle_cnt++;
        if (cycle_cnt == CYCLE_MAX) begin
            failures++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        checks = 0;
        cycle_cnt = 0;
        rst = 1'h1;
        remap_cap_en = 1'h1;
        regspace_locked = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 12'h000;
        reg_be = 8'h00;
        reg_wdata = 64'h0;
        mem_valid = 1'h0;
        mem_addr = 64'h0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        check({62'h0, chan1_remap_window_en, chan0_remap_window_en}, 64'h0);
        reg_read(12'h020, 1'h1, 64'h0);
        reg_read(12'h028, 1'h1, 64'h0);
        mem_probe(64'h0, 1'h0, 64'h0);
        for (int i = 0; i < NROWS; i++) begin
            case (rows[i].k)
                2'h0: reg_write(rows[i].a[11:0], rows[i].b, rows[i].d, rows[i].f);
                2'h1: reg_read(rows[i].a[11:0], rows[i].f, rows[i].e);
                default: mem_probe(rows[i].a, rows[i].f, rows[i].e);
            endcase
        end
        check({62'h0, chan1_remap_window_en, chan0_remap_window_en}, 64'h3);
        // Both lock sources: capability off, then parent space locked
        for (int i = 0; i < 2; i++) begin
            remap_cap_en = (i == 1);
            regspace_locked = (i == 1);
            reg_write(12'h028, 8'hFF, 64'h0, 1'h1);
            reg_read(12'h028, 1'h1, 64'h0000_0000_1234_5001);
            check({63'h0, chan1_remap_window_en}, 64'h1);
        end
        remap_cap_en = 1'h1;
        regspace_locked = 1'h0;
        // Write then read on the very next cycle must see the new value
        reg_wr = 1'h1;
        reg_addr = 12'h020;
        reg_be = 8'hFF;
        reg_wdata = 64'h0;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'h0;
        reg_rd = 1'h1;
        check({63'h0, reg_ack}, 64'h1);
        @(posedge clk_sys);
        #1;
        reg_rd = 1'h0;
        check({63'h0, reg_ack}, 64'h1);
        check(reg_rdata, 64'h0);
        check({63'h0, chan0_remap_window_en}, 64'h0);
        @(posedge clk_sys);
        #1;
        mem_probe(64'h0000_0000_1234_5010, 1'h1, 64'h2010);
        // Reset again in mid-run clears the programmed window
        rst = 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'h0;
        reg_read(12'h028, 1'h1, 64'h0);
        check({63'h0, chan1_remap_window_en}, 64'h0);
        mem_probe(64'h0000_0000_1234_5010, 1'h0, 64'h0);
        results();
    end
endmodule
